//--- mgc_top.sv
// Motor gate control and carrier period registers with bus slave
module mgc_top (
  // Clock and resets
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              STANDBY,
  // Register bus, 16-bit data with byte lanes
  input  wire logic [3:0]        BUS_ADDR,
  input  wire logic              BUS_WR,
  input  wire logic              BUS_RD,
  input  wire logic [1:0]        BUS_BE,
  input  wire logic [15:0]       BUS_WDATA,
  output logic      [15:0]       BUS_RDATA,
  // Timer status from the counter and mode logic
  input  wire mgc_pkg::mgc_mode_t PWM_MODE,
  input  wire logic              CNT_RUN,
  input  wire logic              CNT_RESTART,
  input  wire logic              CNT_PEAK,
  input  wire logic              PERIOD_XFER,
  // Feedback and raw waveforms
  input  wire logic [2:0]        FB_CAPTURE,
  input  wire logic [5:0]        PWM_IN,
  // Phase pins {w-, v-, u-, w+, v+, u+}
  output logic      [5:0]        PIN_OUT,
  // Channel 3 counter preload
  output logic                   CH3_LOAD,
  output logic      [15:0]       CH3_LOAD_VALUE
);
  import mgc_pkg::*;
  `include "mgc_map.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Registers and internal wiring

  logic [6:0]  gate_bits;
  logic [15:0] dead_time_data;
  logic [15:0] carrier_period_data;
  logic [15:0] carrier_period_buffer;
  logic        clr;
  logic        word_wr;
  logic        lo_wr;
  logic [15:0] next_rdata;

  mgc_ctl_if ctl ();

  // Power-on reset and standby both clear; manual reset never reaches here
  assign clr = RST || STANDBY;

  // Word registers only take writes with both lanes enabled
  assign word_wr = BUS_WR && (BUS_BE == 2'b11);
  assign lo_wr   = BUS_WR && BUS_BE[0];

  ////////////////////////////////////////////////////////////////////////////
  // Interface drive

  assign ctl.gate_control_reg    = {1'b1, gate_bits};
  assign ctl.mode                = PWM_MODE;
  assign ctl.capture_fb          = FB_CAPTURE;
  assign ctl.pwm_in              = PWM_IN;
  assign ctl.sub_run             = CNT_RUN;
  assign ctl.sub_peak            = CNT_PEAK;
  assign ctl.sub_restart         = CNT_RESTART && (PWM_MODE == MGC_MODE_CPWM);
  assign ctl.carrier_period_data = carrier_period_data;

  ////////////////////////////////////////////////////////////////////////////
  // Sub units

  mgc_gate_logic u_gate (
    .ctl (ctl.gate)
  );

  mgc_sub_counter u_sub (
    .clk (CORE_CLK),
    .clr (clr),
    .ctl (ctl.sub)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Gate control sits in the low lane; a byte or a word write reaches it
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      gate_bits <= 7'(`MGC_RST_GATE_CONTROL & 8'h7f);
    end else if (lo_wr && BUS_ADDR == `MGC_OFS_GATE_CONTROL) begin
      gate_bits <= BUS_WDATA[6:0];
    end
  end

  // Dead-time offset, word access only
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      dead_time_data <= `MGC_RST_WORD;
    end else if (word_wr && BUS_ADDR == `MGC_OFS_DEAD_TIME) begin
      dead_time_data <= BUS_WDATA;
    end
  end

  // Carrier period: the transfer from the buffer wins over a direct write
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      carrier_period_data <= `MGC_RST_WORD;
    end else if (PERIOD_XFER) begin
      carrier_period_data <= carrier_period_buffer;
    end else if (word_wr && BUS_ADDR == `MGC_OFS_CARRIER_PERIOD) begin
      carrier_period_data <= BUS_WDATA;
    end
  end

  // Carrier period buffer
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      carrier_period_buffer <= `MGC_RST_WORD;
    end else if (word_wr && BUS_ADDR == `MGC_OFS_CARRIER_BUFFER) begin
      carrier_period_buffer <= BUS_WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Byte reads of a word register return zero rather than half a word
  always_comb begin
    next_rdata = 16'h0000;
    case (BUS_ADDR)
      `MGC_OFS_GATE_CONTROL: begin
        if (BUS_BE[0]) begin
          next_rdata = {8'h00, ctl.gate_control_reg};
        end
      end
      `MGC_OFS_SUB_COUNTER: begin
        if (BUS_BE == 2'b11) begin
          next_rdata = ctl.sub_counter;
        end
      end
      `MGC_OFS_DEAD_TIME: begin
        if (BUS_BE == 2'b11) begin
          next_rdata = dead_time_data;
        end
      end
      `MGC_OFS_CARRIER_PERIOD: begin
        if (BUS_BE == 2'b11) begin
          next_rdata = carrier_period_data;
        end
      end
      `MGC_OFS_CARRIER_BUFFER: begin
        if (BUS_BE == 2'b11) begin
          next_rdata = carrier_period_buffer;
        end
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Read data registered; it holds until the next read or a clear
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      BUS_RDATA <= 16'h0000;
    end else if (BUS_RD) begin
      BUS_RDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Pins registered so they cannot glitch on feedback changes
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      PIN_OUT <= 6'h00;
    end else begin
      PIN_OUT <= ctl.pin_next;
    end
  end

  // Offset preload toward channel 3 on a clear-and-restart
  always_ff @(posedge CORE_CLK) begin
    if (clr) begin
      CH3_LOAD       <= 1'b0;
      CH3_LOAD_VALUE <= `MGC_RST_WORD;
    end else begin
      CH3_LOAD       <= ctl.sub_restart;
      CH3_LOAD_VALUE <= dead_time_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_gate_reserved: assert property (@(posedge CORE_CLK)
    ctl.gate_control_reg[`MGC_BIT_RESERVED] == 1'b1)
    else $error("Gate control reserved bit not 1");

  a_gate_reset: assert property (@(posedge CORE_CLK)
    $past(clr) |-> ctl.gate_control_reg == `MGC_RST_GATE_CONTROL)
    else $error("Gate control not 0x80 after reset");

  a_word_reset: assert property (@(posedge CORE_CLK)
    $past(clr) |-> (dead_time_data == 16'hffff && carrier_period_data == 16'hffff &&
                    carrier_period_buffer == 16'hffff))
    else $error("Word registers not all ones after reset");

  a_byte_ignored: assert property (@(posedge CORE_CLK) disable iff (clr)
    (BUS_WR && BUS_BE != 2'b11 && BUS_ADDR == `MGC_OFS_DEAD_TIME)
    |=> $stable(dead_time_data))
    else $error("Byte write changed a word register");

  a_period_xfer: assert property (@(posedge CORE_CLK) disable iff (clr)
    PERIOD_XFER |=> carrier_period_data == $past(carrier_period_buffer))
    else $error("Buffer not copied into carrier period");

  a_ch3_preload: assert property (@(posedge CORE_CLK) disable iff (clr)
    (CNT_RESTART && PWM_MODE == MGC_MODE_CPWM)
    |=> (CH3_LOAD && CH3_LOAD_VALUE == $past(dead_time_data)) ##1
        (!CH3_LOAD || $past(CNT_RESTART)))
    else $error("Dead-time offset not preloaded");

  a_pass_through: assert property (@(posedge CORE_CLK) disable iff (clr)
    (PWM_MODE == MGC_MODE_OTHER) |=> PIN_OUT == $past(PWM_IN))
    else $error("Pins modified outside PWM modes");

  a_pattern_off: assert property (@(posedge CORE_CLK) disable iff (clr)
    (PWM_MODE == MGC_MODE_CPWM && gate_bits[6] && gate_bits[3] &&
     (gate_bits[2:0] == 3'h0 || gate_bits[2:0] == 3'h7)) |=> PIN_OUT == 6'h00)
    else $error("Pins on with all-off phase pattern");

  a_pattern_direct: assert property (@(posedge CORE_CLK) disable iff (clr)
    (PWM_MODE == MGC_MODE_RSPWM && gate_bits[6:3] == 4'b1001 && gate_bits[2:0] == 3'h1)
    |=> PIN_OUT == 6'h21)
    else $error("Wrong direct gate pattern for U+ W-");

  a_neg_chop: assert property (@(posedge CORE_CLK) disable iff (clr)
    (PWM_MODE == MGC_MODE_CPWM && gate_bits[6:3] == 4'b1101 && gate_bits[2:0] == 3'h2)
    |=> PIN_OUT == {2'b00, $past(PWM_IN[3]), 3'b010})
    else $error("Negative pins not chopped with PWM");

  a_fb_capture: assert property (@(posedge CORE_CLK) disable iff (clr)
    (PWM_MODE == MGC_MODE_CPWM && gate_bits[6:3] == 4'b1000 && FB_CAPTURE == 3'h4)
    |=> PIN_OUT == 6'h14)
    else $error("Capture feedback not used for the pattern");

  a_read_gate: assert property (@(posedge CORE_CLK) disable iff (clr)
    (BUS_RD && BUS_BE[0] && BUS_ADDR == `MGC_OFS_GATE_CONTROL)
    |=> BUS_RDATA == {8'h00, 1'b1, $past(gate_bits)})
    else $error("Gate control read mismatch");

endmodule : mgc_top

//--- mgc_map.svh
// Register map, field positions and reset values of the motor gate block
// Function
// - Gate control resets to 0x80, not manual reset
// - Gate settings act only in both PWM modes
// - Gate control bit 7 reads 1, write 1
// - Motor gate mode picks ordinary or gate output
// - Reverse-side mix chops negative pins with PWM
// - Forward-side mix chops positive pins with PWM
// - Feedback select picks capture inputs or force bits
// - Force bits replace feedback only when selected
// - Phase pattern table drives six pins on/off
// - Subcounter 16-bit read-only, clears at power reset
// - Restart loads dead-time value into channel 3
// - Dead-time, period, buffer reset to 0xFFFF
// - Period match turns subcounter from down to up
// - Buffer copies into period at transfer timing
// - Sixteen-bit registers accept only word access
// - Eight-bit registers accept byte and word access
`ifndef MGC_MAP_SVH
`define MGC_MAP_SVH

// Byte addresses on the 16-bit register bus
`define MGC_OFS_GATE_CONTROL    4'h0
`define MGC_OFS_SUB_COUNTER     4'h2
`define MGC_OFS_DEAD_TIME       4'h4
`define MGC_OFS_CARRIER_PERIOD  4'h6
`define MGC_OFS_CARRIER_BUFFER  4'h8

// Gate control field positions
`define MGC_BIT_RESERVED        7
`define MGC_BIT_MOTOR_GATE      6
`define MGC_BIT_NEG_MIX         5
`define MGC_BIT_POS_MIX         4
`define MGC_BIT_FB_SELECT       3

// Reset values
`define MGC_RST_GATE_CONTROL    8'h80
`define MGC_RST_SUB_COUNTER     16'h0000
`define MGC_RST_WORD            16'hffff

`endif

//--- mgc_pkg.sv
// Types shared by the motor gate and carrier period block
package mgc_pkg;

  // Timer operating mode as chosen by the mode selection logic
  typedef enum logic [1:0] {
    MGC_MODE_OTHER,
    MGC_MODE_CPWM,
    MGC_MODE_RSPWM
  } mgc_mode_t;

  // Subcounter count direction
  typedef enum logic {
    MGC_DIR_DOWN,
    MGC_DIR_UP
  } mgc_dir_t;

endpackage : mgc_pkg

//--- mgc_ctl_if.sv
// Carrier between the register top and its gate and subcounter units
interface mgc_ctl_if;
  import mgc_pkg::*;

  logic [7:0]  gate_control_reg;
  mgc_mode_t   mode;
  logic [2:0]  capture_fb;
  logic [5:0]  pwm_in;
  logic [5:0]  pin_next;
  logic        sub_run;
  logic        sub_peak;
  logic        sub_restart;
  logic [15:0] carrier_period_data;
  logic [15:0] sub_counter;
  mgc_dir_t    sub_dir;

  // Top drives configuration and reads results
  modport top (
    output gate_control_reg, mode, capture_fb, pwm_in,
    output sub_run, sub_peak, sub_restart, carrier_period_data,
    input  pin_next, sub_counter, sub_dir
  );

  // Combinational gate pattern unit
  modport gate (
    input  gate_control_reg, mode, capture_fb, pwm_in,
    output pin_next
  );

  // Subcounter unit
  modport sub (
    input  mode, sub_run, sub_peak, sub_restart, carrier_period_data,
    output sub_counter, sub_dir
  );
endinterface : mgc_ctl_if

//--- mgc_gate_logic.sv
// Gate pattern generation and chopping for the six phase pins
module mgc_gate_logic (
  // Configuration and pin results
  mgc_ctl_if.gate ctl
);
  import mgc_pkg::*;
  `include "mgc_map.svh"

  logic [2:0] phase;
  logic [5:0] gate_pat;
  logic       active;

  // Feedback source: capture inputs or force bits
  assign phase = ctl.gate_control_reg[`MGC_BIT_FB_SELECT] ?
                 ctl.gate_control_reg[2:0] : ctl.capture_fb;
  assign active = (ctl.mode == MGC_MODE_CPWM) || (ctl.mode == MGC_MODE_RSPWM);

  // Pattern order {w-, v-, u-, w+, v+, u+}
  always_comb begin
    case (phase)
      3'h1:    gate_pat = 6'h21;
      3'h2:    gate_pat = 6'h0a;
      3'h3:    gate_pat = 6'h22;
      3'h4:    gate_pat = 6'h14;
      3'h5:    gate_pat = 6'h11;
      3'h6:    gate_pat = 6'h0c;
      default: gate_pat = 6'h00;
    endcase
  end

  // Chop by AND with the PWM wave, or pass the compare outputs through
  always_comb begin
    if (active && ctl.gate_control_reg[`MGC_BIT_MOTOR_GATE]) begin
      ctl.pin_next[2:0] = ctl.gate_control_reg[`MGC_BIT_POS_MIX] ?
                          (gate_pat[2:0] & ctl.pwm_in[2:0]) : gate_pat[2:0];
      ctl.pin_next[5:3] = ctl.gate_control_reg[`MGC_BIT_NEG_MIX] ?
                          (gate_pat[5:3] & ctl.pwm_in[5:3]) : gate_pat[5:3];
    end else begin
      ctl.pin_next = ctl.pwm_in;
    end
  end

endmodule : mgc_gate_logic

//--- mgc_sub_counter.sv
// Complementary-mode subcounter with carrier period compare
module mgc_sub_counter (
  // Clock and power-on or standby clear
  input  wire logic clk,
  input  wire logic clr,
  // Control and count
  mgc_ctl_if.sub    ctl
);
  import mgc_pkg::*;
  `include "mgc_map.svh"

  logic match;

  assign match = (ctl.sub_counter == ctl.carrier_period_data);

  // Direction: peak turns it down, period match turns it up
  always_ff @(posedge clk) begin
    if (clr || ctl.sub_restart) begin
      ctl.sub_dir <= MGC_DIR_DOWN;
    end else if (ctl.mode == MGC_MODE_CPWM && ctl.sub_run) begin
      case (ctl.sub_dir)
        MGC_DIR_DOWN: if (match) ctl.sub_dir <= MGC_DIR_UP;
        MGC_DIR_UP:   if (ctl.sub_peak) ctl.sub_dir <= MGC_DIR_DOWN;
        default:      ctl.sub_dir <= MGC_DIR_DOWN;
      endcase
    end
  end

  // Count only while running in complementary mode
  always_ff @(posedge clk) begin
    if (clr || ctl.sub_restart) begin
      ctl.sub_counter <= `MGC_RST_SUB_COUNTER;
    end else if (ctl.mode == MGC_MODE_CPWM && ctl.sub_run) begin
      if (ctl.sub_dir == MGC_DIR_UP || match) begin
        ctl.sub_counter <= ctl.sub_counter + 16'h0001;
      end else begin
        ctl.sub_counter <= ctl.sub_counter - 16'h0001;
      end
    end
  end

  // Reversal lands within one cycle of the match
  a_sub_reverse: assert property (@(posedge clk) disable iff (clr)
    (ctl.mode == MGC_MODE_CPWM && ctl.sub_run && !ctl.sub_restart &&
     ctl.sub_dir == MGC_DIR_DOWN && match) |=> ctl.sub_dir == MGC_DIR_UP)
    else $error("Subcounter did not reverse on period match");

  a_sub_idle: assert property (@(posedge clk) disable iff (clr)
    (ctl.mode == MGC_MODE_OTHER && !ctl.sub_restart) |=> $stable(ctl.sub_counter))
    else $error("Subcounter moved outside complementary mode");

endmodule : mgc_sub_counter

//--- mgc_stage_model.sv
// Three-phase power stage model: hall feedback and shoot-through watch
module mgc_stage_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Commutation request and gate pins
  input  wire logic       step,
  input  wire logic [5:0] pins,
  input  wire logic       watch,
  // Hall code {w,v,u} and leg fault count
  output logic      [2:0] hall,
  output int              shoot
);
  logic [2:0] pos;

  // Rotor moves one sector per step; only six legal hall codes exist
  always_ff @(posedge clk) begin
    if (rst) pos <= 3'h0;
    else if (step) pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
  end

  // Sector to hall code
  always_comb begin
    case (pos)
      3'h0:    hall = 3'h1;
      3'h1:    hall = 3'h3;
      3'h2:    hall = 3'h2;
      3'h3:    hall = 3'h6;
      3'h4:    hall = 3'h4;
      default: hall = 3'h5;
    endcase
  end

  // Both switches of one leg on would short the supply rail
  always_ff @(posedge clk) begin
    if (rst) shoot <= 0;
    else if (watch && |(pins[5:3] & pins[2:0])) shoot <= shoot + 1;
  end
endmodule : mgc_stage_model

//--- tb.sv
// Self-checking bench of the motor gate and carrier period block
`include "mgc_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mgc_pkg::*;

  typedef struct {string name; logic [15:0] v;} mgc_note_t;

  logic        CORE_CLK, RST, STANDBY, BUS_WR, BUS_RD, CNT_RUN, CNT_RESTART, PERIOD_XFER;
  logic [3:0]  BUS_ADDR;
  logic [1:0]  BUS_BE;
  logic [15:0] BUS_WDATA, BUS_RDATA, CH3_LOAD_VALUE;
  mgc_mode_t   PWM_MODE;
  logic [2:0]  FB_CAPTURE;
  logic [5:0]  PWM_IN, PIN_OUT;
  logic        CH3_LOAD, CNT_PEAK, step, watch, pin_req;
  logic [1:0]  rd_due = 2'h0;
  logic [1:0]  pin_due = 2'h0;
  logic [7:0]  ctl;
  logic [15:0] wv [3];
  logic [3:0]  wofs [3] = '{`MGC_OFS_DEAD_TIME, `MGC_OFS_CARRIER_PERIOD, `MGC_OFS_CARRIER_BUFFER};
  int          shoot, miscompares, check_count, seed;
  mgc_note_t   notes [$];

  mgc_top dut (.CORE_CLK(CORE_CLK), .RST(RST), .STANDBY(STANDBY), .BUS_ADDR(BUS_ADDR),
    .BUS_WR(BUS_WR), .BUS_RD(BUS_RD), .BUS_BE(BUS_BE), .BUS_WDATA(BUS_WDATA),
    .BUS_RDATA(BUS_RDATA), .PWM_MODE(PWM_MODE), .CNT_RUN(CNT_RUN), .CNT_RESTART(CNT_RESTART),
    .CNT_PEAK(CNT_PEAK), .PERIOD_XFER(PERIOD_XFER), .FB_CAPTURE(FB_CAPTURE), .PWM_IN(PWM_IN),
    .PIN_OUT(PIN_OUT), .CH3_LOAD(CH3_LOAD), .CH3_LOAD_VALUE(CH3_LOAD_VALUE));

  mgc_stage_model stage (.clk(CORE_CLK), .rst(RST), .step(step), .pins(PIN_OUT),
    .watch(watch), .hall(FB_CAPTURE), .shoot(shoot));

  ////////////////////////////////////////////////////////////////////////////////////////
  // Expected pin pattern {w-,v-,u-,w+,v+,u+}
  function automatic logic [5:0] gate_exp(logic [7:0] c, mgc_mode_t m, logic [2:0] cap,
                                          logic [5:0] pw);
    logic [5:0] p;
    case (c[3] ? c[2:0] : cap)
      3'h1:    p = 6'h21;
      3'h2:    p = 6'h0a;
      3'h3:    p = 6'h22;
      3'h4:    p = 6'h14;
      3'h5:    p = 6'h11;
      3'h6:    p = 6'h0c;
      default: p = 6'h00;
    endcase
    if (c[4]) p[2:0] = p[2:0] & pw[2:0];
    if (c[5]) p[5:3] = p[5:3] & pw[5:3];
    if (m == MGC_MODE_OTHER || !c[6]) p = pw;
    return p;
  endfunction : gate_exp

  task automatic edge1;
    @(posedge CORE_CLK);
    #1;
  endtask : edge1

  task automatic note(input string n, input logic [15:0] v);
    mgc_note_t e;
    e.name = n;
    e.v = v;
    notes.push_back(e);
  endtask : note

  // Strobes drop for one idle cycle so no signal is set twice in one step
  task automatic bus_wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
    BUS_ADDR = a;
    BUS_BE = be;
    BUS_WDATA = d;
    BUS_WR = 1'b1;
    edge1;
    BUS_WR = 1'b0;
    edge1;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a, input logic [1:0] be, input logic [15:0] x,
                        input string n);
    note(n, x);
    BUS_ADDR = a;
    BUS_BE = be;
    BUS_RD = 1'b1;
    edge1;
    BUS_RD = 1'b0;
    edge1;
  endtask : bus_rd

  task automatic pin_chk(input logic [7:0] c, input mgc_mode_t m);
    PWM_MODE = m;
    PWM_IN = 6'($random(seed));
    note("pins", {10'h0, gate_exp(c, m, FB_CAPTURE, PWM_IN)});
    pin_req = 1'b1;
    edge1;
    pin_req = 1'b0;
    edge1;
  endtask : pin_chk

  task automatic take(input logic [15:0] seen);
    mgc_note_t e;
    check_count++;
    if (notes.size() == 0) begin
      miscompares++;
      $display("mismatch unexpected result exp none seen %h", seen);
    end else begin
      e = notes.pop_front();
      if (seen !== e.v) begin
        miscompares++;
        $display("mismatch %s exp %h seen %h", e.name, e.v, seen);
      end
    end
  endtask : take

  task automatic end_sim;
    if (notes.size() != 0 || shoot != 0) begin
      miscompares++;
      $display("mismatch leftover notes exp 0 seen %0d shoot %0d", notes.size(), shoot);
    end
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    CORE_CLK = 1'b0;
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end

  // Results are due two edges after their request, giving registered outputs slack
  always @(posedge CORE_CLK) begin
    rd_due <= {rd_due[0], BUS_RD === 1'b1 && RST === 1'b0 && STANDBY === 1'b0};
    pin_due <= {pin_due[0], pin_req};
  end
  always @(negedge CORE_CLK) begin
    if (rd_due[1]) take(BUS_RDATA);
    if (pin_due[1]) take({10'h0, PIN_OUT});
    if (CH3_LOAD === 1'b1) take(CH3_LOAD_VALUE);
  end

  // Main sequence
  initial begin
    seed = 36134;
    {RST, STANDBY, BUS_WR, BUS_RD, CNT_RUN, CNT_RESTART, PERIOD_XFER} = 7'h40;
    {step, watch, pin_req, BUS_ADDR, BUS_BE, BUS_WDATA, PWM_IN} = '0;
    CNT_PEAK = 1'b0;
    PWM_MODE = MGC_MODE_OTHER;
    repeat (10) @(posedge CORE_CLK);
    #1 RST = 1'b0;
    for (int r = 0; r < 2; r++) begin
      bus_rd(`MGC_OFS_GATE_CONTROL, 2'h3, 16'h0080, "gate reset");
      bus_rd(`MGC_OFS_SUB_COUNTER, 2'h3, 16'h0000, "sub reset");
      foreach (wofs[i]) bus_rd(wofs[i], 2'h3, 16'hffff, "word reset");
      bus_rd(4'ha, 2'h3, 16'h0000, "unmapped");
      if (r == 0) begin
        foreach (wofs[i]) begin
          wv[i] = 16'($random(seed));
          bus_wr(wofs[i], 2'h3, wv[i]);
          bus_wr(wofs[i], 2'h1, ~wv[i]);
          bus_rd(wofs[i], 2'h3, wv[i], "word rw");
          bus_rd(wofs[i], 2'h2, 16'h0000, "byte read");
        end
        bus_wr(`MGC_OFS_SUB_COUNTER, 2'h3, 16'h1234);
        bus_rd(`MGC_OFS_SUB_COUNTER, 2'h3, 16'h0000, "sub ro");
        bus_wr(`MGC_OFS_GATE_CONTROL, 2'h1, 16'h0055);
        bus_rd(`MGC_OFS_GATE_CONTROL, 2'h1, 16'h00d5, "gate byte");
        bus_wr(`MGC_OFS_GATE_CONTROL, 2'h3, 16'hff00);
        bus_rd(`MGC_OFS_GATE_CONTROL, 2'h3, 16'h0080, "gate word");
        // Period takes the buffer value on the transfer pulse
        PERIOD_XFER = 1'b1;
        edge1;
        PERIOD_XFER = 1'b0;
        bus_rd(`MGC_OFS_CARRIER_PERIOD, 2'h3, wv[2], "period xfer");
        bus_wr(`MGC_OFS_CARRIER_BUFFER, 2'h3, 16'hfff0);
        PERIOD_XFER = 1'b1;
        edge1;
        PERIOD_XFER = 1'b0;
        // Restart preloads channel 3 in CPWM only; the OTHER pulse must stay silent
        for (int m = 1; m >= 0; m--) begin
          PWM_MODE = mgc_mode_t'(m);
          if (m == 1) note("ch3 load", wv[0]);
          CNT_RESTART = 1'b1;
          edge1;
          CNT_RESTART = 1'b0;
          CNT_RUN = 1'b1;
          repeat (m ? 20 : 5) edge1;
          // Peak turns the count down again: one up step, then one down step
          CNT_PEAK = 1'(m);
          edge1;
          CNT_PEAK = 1'b0;
          edge1;
          CNT_RUN = 1'b0;
          edge1;
          bus_rd(`MGC_OFS_SUB_COUNTER, 2'h3, 16'hfff4, "sub count");
        end
        // Forced patterns in both PWM modes
        watch = 1'b1;
        for (int m = 1; m <= 2; m++) begin
          for (int p = 0; p < 8; p++) begin
            ctl = 8'hc8 | 8'(p);
            bus_wr(`MGC_OFS_GATE_CONTROL, 2'h1, {8'h00, ctl});
            pin_chk(ctl, mgc_mode_t'(m));
          end
        end
        // Hall feedback from the stage with force bits ignored
        for (int s = 0; s < 6; s++) begin
          step = 1'b1;
          edge1;
          step = 1'b0;
          ctl = 8'hc0 | 8'($random(seed) & 7);
          bus_wr(`MGC_OFS_GATE_CONTROL, 2'h1, {8'h00, ctl});
          pin_chk(ctl, MGC_MODE_CPWM);
        end
        watch = 1'b0;
        // Random chopping and mode mix, passthrough outside gate mode
        for (int k = 0; k < 16; k++) begin
          ctl = 8'h80 | 8'($random(seed));
          bus_wr(`MGC_OFS_GATE_CONTROL, 2'h1, {8'h00, ctl});
          pin_chk(ctl, mgc_mode_t'(k % 3));
        end
        STANDBY = 1'b1;
        edge1;
        STANDBY = 1'b0;
      end
    end
    edge1;
    end_sim;
  end
endmodule : tb
